// >>> rtl/dac_channel_update_control.sv
// Channel data, update, clear, toggle and indicator logic of the converter
`timescale 1ns/1ns
`include "dac_update_consts.svh"
//
// Behaviour
// - Data codes are 12-bit twos complement
// - Reset clears every data register to zero
// - Four independently configured subsystems hold all channels
// - Each channel has data registers A and B
// - Writes land in buffer; output follows active
// - Data reads return buffer, never active stage
// - Strobe low: writes copy straight to active
// - Strobe high: active holds until load trigger
// - Strobe falling edge loads all channels together
// - Control bit 15 loads selected subsystem only
// - Clear shows zero, keeps data, stays writable
// - Leaving clear shows active value at once
// - Clear pin low clears all channels
// - Zero field bits 5:4 clear one subsystem
// - Trigger rise arms; each fall swaps A/B
// - Auto-negate loads B with minus written A
// - Writing B never alters register A
// - Indicator low for A, high for B at divider zero
// - Indicator high impedance until subsystem-1 drive field
// - Indicator flips every 2^N trigger pulses
// - Without trigger rise, register A drives outputs
// - Accesses act on pointer-selected subsystem, default 1
module dac_channel_update_control #(
    parameter int NUM_SUB    = `NUM_SUB,
    parameter int CH_PER_SUB = `CH_PER_SUB
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   load_strobe,
    input  wire logic                   zero_all_n,
    input  wire logic                   square_wave_edge_pin,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire dac_update_pkg::addr_t  reg_addr,
    input  wire dac_update_pkg::word_t  reg_wdata,
    output dac_update_pkg::word_t       reg_rdata,
    output logic                        reg_rvalid,
    output logic [NUM_SUB*CH_PER_SUB*`CODE_W-1:0] chan_code,
    output logic                        active_reg_indicator,
    output logic                        active_reg_indicator_oe_n
);
    import dac_update_pkg::*;

    localparam int NCH = NUM_SUB * CH_PER_SUB;
    localparam int IW  = $clog2(NCH + 8);

    // Register state, one settings word and divider per subsystem
    word_t              ctrl_r [NUM_SUB];
    logic [`DIV_W-1:0]  div_r  [NUM_SUB];
    logic [1:0]         subsystem_select_r;
    logic [4:0]         channel_pointer_r;
    code_t              buf_a  [NCH];
    code_t              buf_b  [NCH];
    code_t              act_a  [NCH];
    code_t              act_b  [NCH];
    toggle_st_e         tg_r;
    logic [6:0]         pulse_cnt_r;

    // Decode and pin events
    logic               load_strobe_lvl;
    logic               load_strobe_fall;
    logic               clr_lvl;
    logic               trig_rise;
    logic               trig_fall;
    logic               wr_a;
    logic               wr_b;
    logic               wr_ctrl;
    logic               ch_ok;
    logic               autoneg;
    logic               sel_b;
    logic               trig_pulse;
    logic [IW-1:0]      idx;
    code_t              wcode;
    code_t              wneg;
    logic [NUM_SUB-1:0] sub_load;
    logic [NUM_SUB-1:0] sub_clr;
    logic [6:0]         div_lim;
    word_t              ptr_word;

    // Flat channel number from subsystem and in-subsystem pointer
    function automatic logic [IW-1:0] chan_idx(input logic [1:0] s,
                                               input logic [4:0] p);
        return IW'(s * CH_PER_SUB + p);
    endfunction

    // Arithmetic negative; -2048 has no positive twin and maps to itself
    function automatic code_t neg_code(input code_t c);
        return ~c + `CODE_W'h001;
    endfunction

    // Pin conditioning
    pin_edge_sync #(.IDLE(1'b1)) u_load_strobe (
        .clk  (clk),
        .rst  (rst),
        .pin  (load_strobe),
        .lvl  (load_strobe_lvl),
        .rise (),
        .fall (load_strobe_fall)
    );
    pin_edge_sync #(.IDLE(1'b1)) u_clr (
        .clk  (clk),
        .rst  (rst),
        .pin  (zero_all_n),
        .lvl  (clr_lvl),
        .rise (),
        .fall ()
    );
    pin_edge_sync #(.IDLE(1'b0)) u_trig (
        .clk  (clk),
        .rst  (rst),
        .pin  (square_wave_edge_pin),
        .lvl  (),
        .rise (trig_rise),
        .fall (trig_fall)
    );

    // Access decode against the selected subsystem and channel
    assign ch_ok   = channel_pointer_r < 5'(CH_PER_SUB);
    assign idx     = chan_idx(subsystem_select_r, channel_pointer_r);
    assign wr_a    = reg_wr && reg_addr == `ADDR_BUFA && ch_ok;
    assign wr_b    = reg_wr && reg_addr == `ADDR_BUFB && ch_ok;
    assign wr_ctrl = reg_wr && reg_addr == `ADDR_CTRL;
    assign wcode   = reg_wdata[`CODE_W-1:0];
    assign wneg    = neg_code(wcode);
    assign autoneg = ctrl_r[subsystem_select_r]
                         [`CTRL_ANEG_HI:`CTRL_ANEG_LO] != 2'b00;
    assign sel_b   = tg_r == TG_B;
    assign ptr_word = {6'h00, subsystem_select_r, 3'h0, channel_pointer_r};

    // Per-subsystem load and clear requests
    always_comb begin
        for (int s = 0; s < NUM_SUB; s++) begin
            sub_load[s] = wr_ctrl && subsystem_select_r == 2'(s)
                          && reg_wdata[`CTRL_LOAD_BIT];
            sub_clr[s]  = !clr_lvl
                          || ctrl_r[s][`CTRL_ZERO_HI:`CTRL_ZERO_LO]
                             != 2'b00;
        end
    end

    // Pointer register; subsystem 1 selected after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            subsystem_select_r <= `SID_RST;
            channel_pointer_r  <= `CHANNEL_POINTER_RST;
        end else if (reg_wr && reg_addr == `ADDR_PTR) begin
            subsystem_select_r <= reg_wdata[`PTR_SID_HI:`PTR_SID_LO];
            channel_pointer_r  <= reg_wdata[`PTR_CHANNEL_POINTER_HI:`PTR_CHANNEL_POINTER_LO];
        end
    end

    // Settings and divider; load bit is not stored so it self-clears
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int s = 0; s < NUM_SUB; s++) begin
                ctrl_r[s] <= `CTRL_RST;
                div_r[s]  <= `DIV_RST;
            end
        end else if (wr_ctrl) begin
            ctrl_r[subsystem_select_r] <= reg_wdata & `CTRL_WMASK;
        end else if (reg_wr && reg_addr == `ADDR_DIV) begin
            div_r[subsystem_select_r] <= reg_wdata[`DIV_W-1:0];
        end
    end

    // Buffer stages; writes stay possible while cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                buf_a[i] <= `CODE_RST;
                buf_b[i] <= `CODE_RST;
            end
        end else begin
            if (wr_a) begin
                buf_a[idx] <= wcode;
                if (autoneg) begin
                    buf_b[idx] <= wneg;
                end
            end
            if (wr_b) begin
                buf_b[idx] <= wcode;
            end
        end
    end

    // Active stages: bulk loads first, an immediate write overrides
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                act_a[i] <= `CODE_RST;
                act_b[i] <= `CODE_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (load_strobe_fall || sub_load[i / CH_PER_SUB]) begin
                    act_a[i] <= buf_a[i];
                    act_b[i] <= buf_b[i];
                end
            end
            // Strobe high leaves active stages alone on writes
            if (!load_strobe_lvl && wr_a) begin
                act_a[idx] <= wcode;
                if (autoneg) begin
                    act_b[idx] <= wneg;
                end
            end
            if (!load_strobe_lvl && wr_b) begin
                act_b[idx] <= wcode;
            end
        end
    end

    // Output codes: zero when cleared, else the selected active stage
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_code <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sub_clr[i / CH_PER_SUB]) begin
                    chan_code[i*`CODE_W +: `CODE_W] <= `CODE_RST;
                end else begin
                    chan_code[i*`CODE_W +: `CODE_W] <=
                        sel_b ? act_b[i] : act_a[i];
                end
            end
        end
    end

    // Toggle state: stays on A until the first trigger rise
    always_ff @(posedge clk) begin
        if (rst) begin
            tg_r <= TG_DC;
        end else begin
            case (tg_r)
                TG_DC: begin
                    if (trig_rise) begin
                        tg_r <= TG_A;
                    end
                end
                TG_A: begin
                    if (trig_fall) begin
                        tg_r <= TG_B;
                    end
                end
                TG_B: begin
                    if (trig_fall) begin
                        tg_r <= TG_A;
                    end
                end
                default: tg_r <= TG_DC;
            endcase
        end
    end

    // Divider is taken from subsystem 1 only; values above 6 clip
    assign trig_pulse = trig_fall && tg_r != TG_DC;
    assign div_lim    = 7'((1 << ((div_r[0] > `DIV_MAX) ? `DIV_MAX
                                                       : div_r[0])) - 1);

    // Indicator flips on every 2^N-th trigger pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt_r          <= 7'h00;
            active_reg_indicator <= 1'b0;
        end else if (trig_pulse) begin
            if (pulse_cnt_r >= div_lim) begin
                pulse_cnt_r          <= 7'h00;
                active_reg_indicator <= ~active_reg_indicator;
            end else begin
                pulse_cnt_r <= pulse_cnt_r + 7'h01;
            end
        end
    end

    // Drive only when subsystem 1 enables it; the host keeps others off
    always_ff @(posedge clk) begin
        if (rst) begin
            active_reg_indicator_oe_n <= 1'b1;
        end else begin
            active_reg_indicator_oe_n <=
                ctrl_r[0][`CTRL_DRV_HI:`CTRL_DRV_LO] == 2'b00;
        end
    end

    // Read port: answer one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_BUFA: reg_rdata <= ch_ok ?
                        {4'h0, buf_a[idx]} : 16'h0000;
                    `ADDR_BUFB: reg_rdata <= ch_ok ?
                        {4'h0, buf_b[idx]} : 16'h0000;
                    `ADDR_CTRL: reg_rdata <= ctrl_r[subsystem_select_r];
                    `ADDR_PTR:  reg_rdata <= ptr_word;
                    `ADDR_DIV:  reg_rdata <= {13'h0000,
                                              div_r[subsystem_select_r]};
                    default:    reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr_a_now;
        wr_a && !load_strobe_lvl;
    endsequence
    sequence s_wr_a_held;
        wr_a && load_strobe_lvl && sub_load == '0;
    endsequence
    sequence s_toggle;
        trig_fall && tg_r != TG_DC;
    endsequence

    AST_ASYNC_LOAD: assert property (
        s_wr_a_now |=> act_a[$past(idx)] == $past(wcode))
        else $error("immediate write did not reach active stage");
    AST_SYNC_HOLD: assert property (
        s_wr_a_held |=> act_a[$past(idx)] == $past(act_a[idx]))
        else $error("active stage changed without a load");
    AST_STROBE_ALL: assert property (
        load_strobe_fall && !reg_wr |=> act_a[0] == $past(buf_a[0])
            && act_a[NCH-1] == $past(buf_a[NCH-1]))
        else $error("strobe edge did not load every channel");
    AST_SUB_ONLY: assert property (
        sub_load == 4'h1 && !load_strobe_fall |=> act_a[0] == $past(buf_a[0])
            && act_a[CH_PER_SUB] == $past(act_a[CH_PER_SUB]))
        else $error("subsystem load wrong in scope");
    AST_CLEAR_PIN: assert property (
        !clr_lvl |=> chan_code == '0)
        else $error("outputs not zero under clear pin");
    AST_READ_BUF: assert property (
        reg_rd && !reg_wr && reg_addr == `ADDR_BUFA && ch_ok
            |=> reg_rvalid && reg_rdata == {4'h0, $past(buf_a[idx])})
        else $error("read did not return buffer stage");
    AST_AUTONEG: assert property (
        wr_a && autoneg |=> buf_b[$past(idx)] == $past(wneg))
        else $error("auto-negate did not load register B");
    AST_B_KEEPS_A: assert property (
        wr_b |=> buf_a[$past(idx)] == $past(buf_a[idx]))
        else $error("write to B altered A");
    AST_TOGGLE: assert property (
        s_toggle |=> sel_b != $past(sel_b) ##1 tg_r != TG_DC)
        else $error("trigger fall did not swap registers");
    AST_DC_STAYS: assert property (
        tg_r == TG_DC && !trig_rise |=> tg_r == TG_DC && !sel_b)
        else $error("left register A without trigger rise");
    AST_DIV_ONE: assert property (
        div_r[0] == 3'h0 && trig_pulse
            |=> active_reg_indicator != $past(active_reg_indicator))
        else $error("indicator missed a flip at divide by one");
    AST_HIZ: assert property (
        ctrl_r[0][`CTRL_DRV_HI:`CTRL_DRV_LO] == 2'b00
            |=> active_reg_indicator_oe_n)
        else $error("indicator driven while disabled");
endmodule // dac_channel_update_control

// >>> rtl/dac_update_consts.svh
// Offsets, field positions, reset values and counts of the update logic
`ifndef DAC_UPDATE_CONSTS_SVH
`define DAC_UPDATE_CONSTS_SVH

// Organisation
`define NUM_SUB       4
`define CH_PER_SUB    24
`define CODE_W        12

// Register offsets
`define ADDR_BUFA     4'h0
`define ADDR_BUFB     4'h1
`define ADDR_CTRL     4'h4
`define ADDR_PTR      4'h6
`define ADDR_DIV      4'h9

// Subsystem settings register fields
`define CTRL_LOAD_BIT 15
`define CTRL_DRV_HI   9
`define CTRL_DRV_LO   8
`define CTRL_ZERO_HI  5
`define CTRL_ZERO_LO  4
`define CTRL_ANEG_HI  1
`define CTRL_ANEG_LO  0
`define CTRL_WMASK    16'h03F3
`define CTRL_RST      16'h0000

// Pointer register fields
`define PTR_CHANNEL_POINTER_HI   4
`define PTR_CHANNEL_POINTER_LO   0
`define PTR_SID_HI    9
`define PTR_SID_LO    8
`define SID_RST       2'h0
`define CHANNEL_POINTER_RST      5'h00

// Indicator divider
`define DIV_W         3
`define DIV_MAX       3'h6
`define DIV_RST       3'h0

// Data reset value: zero scale
`define CODE_RST      12'h000

`endif

// >>> rtl/dac_update_pkg.sv
// Types shared by the channel update logic
`include "dac_update_consts.svh"
package dac_update_pkg;
    typedef logic [3:0]         addr_t;
    typedef logic [15:0]        word_t;
    typedef logic [`CODE_W-1:0] code_t;
    // Gray path: DC -> armed on A -> B -> A ...
    typedef enum logic [1:0] {
        TG_DC = 2'b00,
        TG_A  = 2'b01,
        TG_B  = 2'b11
    } toggle_st_e;
endpackage

// >>> rtl/pin_edge_sync.sv
// Two-flop pin synchroniser with rise and fall detection
`timescale 1ns/1ns
module pin_edge_sync #(
    parameter logic IDLE = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      lvl,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Reset to the idle level so release makes no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= IDLE;
            sync_r <= IDLE;
            last_r <= IDLE;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // One pulse per physical edge
    assign lvl  = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule // pin_edge_sync

// >>> tb/host_model.sv
// Host model: register writes and reads into the update logic
`timescale 1ns/1ns
`include "dac_update_consts.svh"
module host_model (
    input  wire logic                  clk,
    output logic                       reg_wr,
    output logic                       reg_rd,
    output dac_update_pkg::addr_t      reg_addr,
    output dac_update_pkg::word_t      reg_wdata,
    input  wire dac_update_pkg::word_t reg_rdata,
    input  wire logic                  reg_rvalid
);
    import dac_update_pkg::*;

    // Idle bus from time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
    end

    // One write, request held for exactly one taking edge
    task automatic wr(input addr_t a, input word_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // One read; answer is sampled 1 ns after the taking edge
    task automatic rd(input addr_t a, output word_t q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        q = reg_rvalid ? reg_rdata : 'x;
    endtask

    // Subsystem and channel selection through the pointer register
    task automatic point(input int s, input int c);
        wr(`ADDR_PTR, word_t'((s << 8) | c));
    endtask
endmodule // host_model

// >>> tb/tb_top.sv
// Self-checking bench with a reference model of the update logic
`timescale 1ns/1ns
`include "dac_update_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end end
module tb_top;
    import dac_update_pkg::*;
    localparam int NCH = `NUM_SUB * `CH_PER_SUB;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    load_strobe = 1'b1;
    logic                    zero_all_n = 1'b1;
    logic                    trig = 1'b0;
    logic                    reg_wr;
    logic                    reg_rd;
    addr_t                   reg_addr;
    word_t                   reg_wdata;
    word_t                   reg_rdata;
    logic                    reg_rvalid;
    logic [NCH*`CODE_W-1:0]  chan_code;
    logic                    ind;
    logic                    ind_oe_n;
    int                      failures = 0;
    int                      samples_checked = 0;
    int                      cyc = 0;
    int                      fcnt;
    int                      div_n;
    code_t                   bufa[NCH];
    code_t                   bufb[NCH];
    code_t                   acta[NCH];
    code_t                   actb[NCH];
    bit                      aneg[4];
    bit                      zsub[4];
    bit                      selb;
    logic                    ind_m;
    word_t                   q;

    always #4 clk = ~clk;

    host_model host_u (
        .clk        (clk),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid)
    );

    dac_channel_update_control #(
        .NUM_SUB    (`NUM_SUB),
        .CH_PER_SUB (`CH_PER_SUB)
    ) dut_u (
        .clk                       (clk),
        .rst                       (rst),
        .load_strobe               (load_strobe),
        .zero_all_n                (zero_all_n),
        .square_wave_edge_pin      (trig),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_rdata                 (reg_rdata),
        .reg_rvalid                (reg_rvalid),
        .chan_code                 (chan_code),
        .active_reg_indicator      (ind),
        .active_reg_indicator_oe_n (ind_oe_n)
    );

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Waits past the edge so checks never race the design's updates
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pins held idle through reset, model cleared to zero scale
    task automatic reset_dut();
        @(posedge clk);
        rst         <= 1'b1;
        load_strobe <= 1'b1;
        zero_all_n  <= 1'b1;
        trig        <= 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < NCH; i++) begin
            bufa[i] = '0;
            bufb[i] = '0;
            acta[i] = '0;
            actb[i] = '0;
        end
        aneg  = '{default: 1'b0};
        zsub  = '{default: 1'b0};
        selb  = 1'b0;
        ind_m = 1'b0;
        fcnt  = 0;
        div_n = 0;
        settle(4);
    endtask

    // Output seen on channel i: zero when cleared, else selected active
    function automatic code_t expv(input int i);
        if (!zero_all_n || zsub[i / `CH_PER_SUB]) return '0;
        return selb ? actb[i] : acta[i];
    endfunction

    task automatic check_all();
        for (int i = 0; i < NCH; i++)
            `CHK(chan_code[i*`CODE_W +: `CODE_W], expv(i))
    endtask

    // Data write, model update, then read-back of the buffer stage
    task automatic dwr(input int s, input int c, input bit b, input code_t v);
        int i;
        i = s * `CH_PER_SUB + c;
        host_u.point(s, c);
        host_u.wr(b ? `ADDR_BUFB : `ADDR_BUFA, {4'h0, v});
        if (b) bufb[i] = v;
        else begin
            bufa[i] = v;
            if (aneg[s]) bufb[i] = -v;
        end
        if (!load_strobe) begin
            acta[i] = bufa[i];
            actb[i] = bufb[i];
        end
        settle(3);
        host_u.rd(b ? `ADDR_BUFB : `ADDR_BUFA, q);
        `CHK(q, {4'h0, b ? bufb[i] : bufa[i]})
    endtask

    // Settings write; a set load bit copies that subsystem only
    task automatic cwr(input int s, input word_t d);
        host_u.point(s, 0);
        host_u.wr(`ADDR_CTRL, d);
        aneg[s] = |d[1:0];
        zsub[s] = |d[5:4];
        if (d[15])
            for (int c = 0; c < `CH_PER_SUB; c++) begin
                acta[s*`CH_PER_SUB+c] = bufa[s*`CH_PER_SUB+c];
                actb[s*`CH_PER_SUB+c] = bufb[s*`CH_PER_SUB+c];
            end
        settle(3);
        host_u.rd(`ADDR_CTRL, q);
        `CHK(q, d & `CTRL_WMASK)
    endtask

    // Strobe pin level; a fall loads every channel at once
    task automatic set_ld(input logic v);
        @(posedge clk);
        load_strobe <= v;
        if (load_strobe && !v) begin
            acta = bufa;
            actb = bufb;
        end
        settle(8);
    endtask

    task automatic set_clr(input logic v);
        @(posedge clk);
        zero_all_n <= v;
        settle(8);
    endtask

    // Trigger pulse: rise arms, fall swaps, indicator divides falls
    task automatic pulse();
        @(posedge clk);
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        trig <= 1'b0;
        settle(8);
        selb = ~selb;
        fcnt++;
        if (fcnt == (1 << div_n)) begin
            ind_m = ~ind_m;
            fcnt  = 0;
        end
    endtask

    initial begin
        void'($urandom(19));
        reset_dut();
        check_all();
        `CHK(ind_oe_n, 1'b1)
        // Immediate mode across random subsystems and channels
        set_ld(1'b0);
        for (int k = 0; k < 8; k++)
            dwr($urandom%4, $urandom%24, 1'b0, code_t'($urandom));
        dwr(3, 23, 1'b0, 12'h800);
        check_all();
        host_u.rd(4'h3, q);
        `CHK(q, 16'h0000)
        $display("test immediate done");
        // Held strobe, subsystem load bit, then strobe fall
        set_ld(1'b1);
        for (int s = 0; s < 4; s++)
            dwr(s, 5, 1'b0, code_t'($urandom));
        check_all();
        cwr(2, 16'h8000);
        check_all();
        set_ld(1'b0);
        check_all();
        $display("test load done");
        // Clear by pin, data written meanwhile, then subsystem zeroing
        set_clr(1'b0);
        check_all();
        dwr(1, 3, 1'b0, code_t'($urandom));
        check_all();
        set_clr(1'b1);
        check_all();
        cwr(3, 16'h0010);
        check_all();
        cwr(3, 16'h0000);
        check_all();
        $display("test clear done");
        // Divider set right after reset, before any channel data
        reset_dut();
        host_u.rd(`ADDR_PTR, q);
        `CHK(q, 16'h0000)
        host_u.point(0, 0);
        host_u.wr(`ADDR_DIV, 16'h0001);
        div_n = 1;
        host_u.rd(`ADDR_DIV, q);
        `CHK(q, 16'h0001)
        cwr(0, 16'h0101);
        set_ld(1'b0);
        for (int c = 0; c < 4; c++)
            dwr(0, c, 1'b0, code_t'($urandom));
        dwr(0, 0, 1'b1, code_t'($urandom));
        check_all();
        `CHK(ind_oe_n, 1'b0)
        for (int p = 0; p < 4; p++) begin
            pulse();
            check_all();
            `CHK(ind, ind_m)
        end
        $display("test toggle done");
        // Divider left at zero: the indicator follows every swap
        reset_dut();
        cwr(0, 16'h0100);
        for (int p = 0; p < 3; p++) begin
            pulse();
            check_all();
            `CHK(ind, ind_m)
        end
        $display("test divide by one done");
        end_sim();
    end
endmodule // tb_top
